// file: psp_defines.svh
// Register offsets, bit positions, reset values and timing counts of the slave port
`ifndef PSP_DEFINES_SVH
`define PSP_DEFINES_SVH

// ----------------------------------------------------------------------------
// Device register offsets (device address space)
// ----------------------------------------------------------------------------
`define PSP_OFF_DATA        8'h08
`define PSP_OFF_CTRLPIN     8'h09
`define PSP_OFF_IRQ_FLAGS   8'h0C
`define PSP_OFF_STROBE_DIR  8'h89
`define PSP_OFF_IRQ_EN      8'h8C
`define PSP_OFF_ANALOG_CFG  8'h9F

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PSP_BIT_IN_FULL     7
`define PSP_BIT_OUT_FULL    6
`define PSP_BIT_IN_OVF      5
`define PSP_BIT_ENABLE      4
`define PSP_BIT_IRQ         7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PSP_RST_STROBE_DIR  8'h07
`define PSP_RST_IRQ_FLAGS   8'h00
`define PSP_RST_IRQ_EN      8'h00
`define PSP_RST_ANALOG_CFG  8'h00

// ----------------------------------------------------------------------------
// Phase clock: four clocks per instruction cycle, phase_two at 1, phase_four at 3
// ----------------------------------------------------------------------------
`define PSP_PHASE_TWO       2'h1
`define PSP_PHASE_FOUR      2'h3

// ----------------------------------------------------------------------------
// Host controller AXI4-Lite register offsets
// ----------------------------------------------------------------------------
`define PSP_AXI_CMD         32'h0000_0000
`define PSP_AXI_WDATA       32'h0000_0004
`define PSP_AXI_RDATA       32'h0000_0008
`define PSP_AXI_STATUS      32'h0000_000C
`define PSP_AXI_IRQ_MASK    32'h0000_0010
`define PSP_CMD_WRITE       0
`define PSP_CMD_READ        1
`define PSP_ST_BUSY         0
`define PSP_EV_WDONE        0
`define PSP_EV_RDONE        1
`define PSP_STROBE_CYC      8

`endif

// file: psp_pkg.sv
// Types shared by both ends of the slave port
package psp_pkg;
  typedef enum logic [3:0] {
    PSP_IDLE  = 4'b0001,
    PSP_SETUP = 4'b0010,
    PSP_HOLD  = 4'b0100,
    PSP_GAP   = 4'b1000
  } psp_host_state_t;

  typedef logic [7:0] psp_byte_t;
endpackage : psp_pkg

// file: psp_bus_if.sv
// Byte-wide host bus between the external processor and the slave port
`timescale 1ns/1ns
interface psp_bus_if;
  import psp_pkg::*;
  logic      cs_n;
  logic      rd_n;
  logic      wr_n;
  psp_byte_t host_data;
  logic      host_data_oe;
  psp_byte_t dev_data;
  logic      dev_data_oe;
  psp_byte_t bus_data;

  // Resolved wire: host wins only if it drives, else device, else pull-up
  assign bus_data = host_data_oe ? host_data : (dev_data_oe ? dev_data : 8'hFF);

  modport device (input cs_n, rd_n, wr_n, bus_data, output dev_data, dev_data_oe);
  modport host   (output cs_n, rd_n, wr_n, host_data, host_data_oe, input bus_data);
endinterface : psp_bus_if

// file: psp_sync.sv
// Two-flop synchroniser for the asynchronous host strobes
`timescale 1ns/1ns
module psp_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // Strobes idle high, so reset to inactive
  always_ff @(posedge CLK) begin
    if (RST) begin
      meta <= '1;
      q    <= '1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : psp_sync

// file: psp_device.sv
// Device end: slave port with its latches, status flags and interrupt flag
//
// Overview of operation
// - Enable bit makes data port a slave
// - Pins 0,1,2 are read, write, select
// - Software sets pins input and digital
// - Two latches share one data address
// - Data direction register ignored in slave mode
// - Write starts when select and write low
// - Write end sets full and irq flags
// - Only firmware read or disable clears input full
// - Write into full latch sets overflow
// - Read start clears output full at once
// - Read end sets irq flag
// - Output full set only by firmware write
// - Disabled mode forces full flags low
// - Firmware clears overflow explicitly
// - Irq flag latched, cleared by firmware, masked
// - Status bits 7,6,5,4 as listed
// - All strobes active low, select qualifies
//
// Local design decision: host controller registers over AXI4-Lite, device registers over REG_WE/REG_RE.
`timescale 1ns/1ns
`include "psp_defines.svh"
module psp_device
  import psp_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // Firmware register port
  input  wire logic       REG_WE,
  input  wire logic       REG_RE,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  // Data direction used outside slave mode
  input  wire logic [7:0] DATA_PIN_DIRECTION,
  output logic      [7:0] DATA_OUT_OE,
  // Interrupt
  output logic            IRQ,
  // Host bus
  psp_bus_if.device       bus
);
  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic       slave_port_enable;
  logic [2:0] strobe_dir;
  logic       in_buf_full;
  logic       out_buf_full;
  logic       in_buf_overflow;
  logic [7:0] irq_flags;
  logic [7:0] irq_enables;
  logic [2:0] pin_analog_config;
  psp_byte_t  out_latch;
  psp_byte_t  in_latch;
  logic [1:0] phase;
  // --------------------------------------------------------------------------
  // Strobe synchronisation and decoding
  // --------------------------------------------------------------------------
  logic [2:0] strobe_s;
  logic       rd_act;
  logic       wr_act;
  logic       rd_act_d;
  logic       wr_act_d;
  logic       rd_pend;
  logic       wr_pend;
  logic       seen_p2;
  psp_sync #(.WIDTH(3)) psp_sync_inst (.CLK(CLK), .RST(RST), .q(strobe_s),
                                       .d({bus.cs_n, bus.wr_n, bus.rd_n}));
  assign rd_act = slave_port_enable && !strobe_s[2] && !strobe_s[0];
  assign wr_act = slave_port_enable && !strobe_s[2] && !strobe_s[1];
  wire rd_start = rd_act && !rd_act_d;
  // write begins on select, write low
  wire wr_start = wr_act && !wr_act_d;
  wire rd_end   = !rd_act && rd_act_d;
  wire wr_end   = !wr_act && wr_act_d;
  wire at_p2    = (phase == `PSP_PHASE_TWO);
  wire at_p4    = (phase == `PSP_PHASE_FOUR);
  wire done_p4  = at_p4 && seen_p2 && (rd_pend || wr_pend);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit
  wire fw_rd_data = REG_RE && hit(REG_ADDR, `PSP_OFF_DATA);
  wire fw_wr_data = REG_WE && hit(REG_ADDR, `PSP_OFF_DATA);
  wire fw_wr_stat = REG_WE && hit(REG_ADDR, `PSP_OFF_STROBE_DIR);
  wire fw_wr_flag = REG_WE && hit(REG_ADDR, `PSP_OFF_IRQ_FLAGS);
  // --------------------------------------------------------------------------
  // Phase clock
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      rd_act_d <= 1'b0;
      wr_act_d <= 1'b0;
    end else begin
      rd_act_d <= rd_act;
      wr_act_d <= wr_act;
    end
  end
  // completion waits for phase_two then phase_four
  always_ff @(posedge CLK) begin
    if (RST) begin
      rd_pend <= 1'b0;
      wr_pend <= 1'b0;
      seen_p2 <= 1'b0;
    end else begin
      if (done_p4) begin
        rd_pend <= rd_end;
        wr_pend <= wr_end;
        seen_p2 <= 1'b0;
      end else begin
        rd_pend <= rd_pend || rd_end;
        wr_pend <= wr_pend || wr_end;
        if (at_p2 && (rd_pend || wr_pend)) begin
          seen_p2 <= 1'b1;
        end
      end
    end
  end
  // --------------------------------------------------------------------------
  // Latches
  // --------------------------------------------------------------------------
  // pins read directly: synced strobe outlasts the host data
  always_ff @(posedge CLK) begin
    if (RST) begin
      in_latch <= 8'h00;
    end else if (slave_port_enable && !bus.cs_n && !bus.wr_n) begin
      in_latch <= bus.bus_data;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      out_latch <= 8'h00;
    end else if (fw_wr_data) begin
      out_latch <= REG_WDATA;
    end
  end
  // --------------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      in_buf_full <= 1'b0;
    end else if (!slave_port_enable) begin
      in_buf_full <= 1'b0;
    end else if (done_p4 && wr_pend) begin
      // set wins over a clearing read
      in_buf_full <= 1'b1;
    end else if (fw_rd_data) begin
      in_buf_full <= 1'b0;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      out_buf_full <= 1'b0;
    end else if (!slave_port_enable) begin
      out_buf_full <= 1'b0;
    end else if (fw_wr_data) begin
      // only a firmware write sets it
      out_buf_full <= 1'b1;
    end else if (rd_start) begin
      out_buf_full <= 1'b0;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      in_buf_overflow <= 1'b0;
    end else if (wr_start && in_buf_full) begin
      in_buf_overflow <= 1'b1;
    end else if (fw_wr_stat) begin
      in_buf_overflow <= REG_WDATA[`PSP_BIT_IN_OVF];
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      slave_port_enable <= 1'(`PSP_RST_STROBE_DIR >> `PSP_BIT_ENABLE);
      strobe_dir        <= 3'(`PSP_RST_STROBE_DIR);
      pin_analog_config <= 3'(`PSP_RST_ANALOG_CFG);
      irq_enables       <= `PSP_RST_IRQ_EN;
    end else begin
      if (fw_wr_stat) begin
        slave_port_enable <= REG_WDATA[`PSP_BIT_ENABLE];
        strobe_dir        <= REG_WDATA[2:0];
      end
      if (REG_WE && hit(REG_ADDR, `PSP_OFF_ANALOG_CFG)) begin
        pin_analog_config <= REG_WDATA[2:0];
      end
      if (REG_WE && hit(REG_ADDR, `PSP_OFF_IRQ_EN)) begin
        irq_enables <= REG_WDATA;
      end
    end
  end
  // completion flag: set wins over firmware write
  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_flags <= `PSP_RST_IRQ_FLAGS;
    end else begin
      if (fw_wr_flag) begin
        irq_flags <= REG_WDATA;
      end
      if (done_p4) begin
        irq_flags[`PSP_BIT_IRQ] <= 1'b1;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= irq_flags[`PSP_BIT_IRQ] && irq_enables[`PSP_BIT_IRQ];
    end
  end
  // --------------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------------
  // drive only during selected read
  always_ff @(posedge CLK) begin
    if (RST) begin
      bus.dev_data    <= 8'h00;
      bus.dev_data_oe <= 1'b0;
    end else begin
      bus.dev_data    <= out_latch;
      bus.dev_data_oe <= rd_act;
    end
  end
  // direction register ignored in slave mode
  always_ff @(posedge CLK) begin
    if (RST) begin
      DATA_OUT_OE <= 8'h00;
    end else begin
      DATA_OUT_OE <= slave_port_enable ? 8'h00 : ~DATA_PIN_DIRECTION;
    end
  end
  // --------------------------------------------------------------------------
  // Register read
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RE) begin
      case (REG_ADDR)
        `PSP_OFF_DATA:       REG_RDATA <= in_latch;
        `PSP_OFF_CTRLPIN:    REG_RDATA <= {5'h00, strobe_s};
        `PSP_OFF_IRQ_FLAGS:  REG_RDATA <= irq_flags;
        `PSP_OFF_STROBE_DIR: REG_RDATA <= {in_buf_full, out_buf_full, in_buf_overflow,
                                           slave_port_enable, 1'b0, strobe_dir};
        `PSP_OFF_IRQ_EN:     REG_RDATA <= irq_enables;
        `PSP_OFF_ANALOG_CFG: REG_RDATA <= {5'h00, pin_analog_config};
        default:             REG_RDATA <= 8'h00;
      endcase
    end
  end
endmodule : psp_device

// file: psp_host.sv
// Host end: AXI4-Lite controlled external processor driving the byte bus
`timescale 1ns/1ns
`include "psp_defines.svh"
module psp_host
  import psp_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // AXI4-Lite slave
  input  wire logic [31:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [31:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Interrupt
  output logic             IRQ,
  // Byte bus
  psp_bus_if.host          bus
);
  psp_host_state_t state;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic        aw_got;
  logic        w_got;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;
  logic        is_read;
  logic [1:0]  events;
  logic [1:0]  mask;
  logic [7:0]  cnt;

  wire wr_go = aw_got && w_got && !S_AXI_BVALID;
  wire is_cmd = wr_go && aw_addr == `PSP_AXI_CMD && state == PSP_IDLE
                && (w_data[`PSP_CMD_WRITE] || w_data[`PSP_CMD_READ]);
  wire done = state == PSP_GAP && cnt == 8'h00;

  // --------------------------------------------------------------------------
  // AXI write channel: address and data accepted in either order
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'h0;
    end else begin
      S_AXI_AWREADY <= !aw_got && !S_AXI_AWREADY;
      S_AXI_WREADY <= !w_got && !S_AXI_WREADY;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got <= 1'b1;
        w_data <= S_AXI_WDATA;
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (aw_addr <= `PSP_AXI_IRQ_MASK && aw_addr[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Write data byte lane 0, all write strobe lanes ignored: every accepted write updates
  always_ff @(posedge CLK) begin
    if (RST) begin
      wbyte <= 8'h00;
      mask <= 2'h0;
    end else if (wr_go && S_AXI_WSTRB[0] == 1'b1 || wr_go && w_got) begin
      if (aw_addr == `PSP_AXI_WDATA) begin
        wbyte <= w_data[7:0];
      end
      if (aw_addr == `PSP_AXI_IRQ_MASK) begin
        mask <= w_data[1:0];
      end
    end
  end

  // Sticky events, write one to clear; set wins
  always_ff @(posedge CLK) begin
    if (RST) begin
      events <= 2'h0;
    end else begin
      if (wr_go && aw_addr == `PSP_AXI_STATUS) begin
        events <= events & ~w_data[2:1];
      end
      if (done) begin
        events[is_read ? `PSP_EV_RDONE : `PSP_EV_WDONE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(events & mask);
    end
  end

  // --------------------------------------------------------------------------
  // Bus cycle sequencer: strobes active low, data held across the strobe
  // --------------------------------------------------------------------------
  // select, strobe, data held
  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= PSP_IDLE;
      cnt <= 8'h00;
      is_read <= 1'b0;
      rbyte <= 8'h00;
      bus.cs_n <= 1'b1;
      bus.rd_n <= 1'b1;
      bus.wr_n <= 1'b1;
      bus.host_data <= 8'h00;
      bus.host_data_oe <= 1'b0;
    end else begin
      case (state)
        PSP_IDLE: begin
          if (is_cmd) begin
            is_read <= w_data[`PSP_CMD_READ];
            bus.cs_n <= 1'b0;
            bus.host_data <= wbyte;
            bus.host_data_oe <= !w_data[`PSP_CMD_READ];
            state <= PSP_SETUP;
          end
        end
        PSP_SETUP: begin
          bus.rd_n <= !is_read;
          bus.wr_n <= is_read;
          cnt <= 8'(`PSP_STROBE_CYC);
          state <= PSP_HOLD;
        end
        PSP_HOLD: begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h00) begin
            if (is_read) begin
              rbyte <= bus.bus_data;
            end
            bus.rd_n <= 1'b1;
            bus.wr_n <= 1'b1;
            cnt <= 8'(`PSP_STROBE_CYC);
            state <= PSP_GAP;
          end
        end
        PSP_GAP: begin
          bus.cs_n <= 1'b1;
          bus.host_data_oe <= 1'b0;
          cnt <= cnt - 8'h01;
          if (cnt == 8'h00) begin
            state <= PSP_IDLE;
          end
        end
        default: begin
          state <= PSP_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // AXI read channel
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= 2'h0;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= 2'h0;
        case (S_AXI_ARADDR)
          `PSP_AXI_CMD:      S_AXI_RDATA <= 32'h0000_0000;
          `PSP_AXI_WDATA:    S_AXI_RDATA <= {24'h000000, wbyte};
          `PSP_AXI_RDATA:    S_AXI_RDATA <= {24'h000000, rbyte};
          `PSP_AXI_STATUS:   S_AXI_RDATA <= {29'h0, events, state != PSP_IDLE};
          `PSP_AXI_IRQ_MASK: S_AXI_RDATA <= {30'h0, mask};
          default: begin
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= 2'h2;
          end
        endcase
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule : psp_host

// file: psp_monitor.sv
// Assertion monitor for the byte bus joining host and slave port
`timescale 1ns/1ns
module psp_monitor
  import psp_pkg::*;
(
  // Clock and reset
  input wire logic      CLK,
  input wire logic      RST,
  // Byte bus
  input wire logic      cs_n,
  input wire logic      rd_n,
  input wire logic      wr_n,
  input wire psp_byte_t host_data,
  input wire logic      host_data_oe,
  input wire logic      dev_data_oe
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic sel_rd;
  assign sel_rd = !cs_n && !rd_n;
  // ------------------------------------------------------------
  // Steps of a transfer
  // ------------------------------------------------------------
  sequence wr_start_s;
    $fell(wr_n) ##0 !cs_n;
  endsequence
  sequence rd_held_s;
    sel_rd [*5];
  endsequence
  sequence any_strobe_s;
    !rd_n || !wr_n;
  endsequence
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  wr_select_a: assert property (!wr_n |-> !cs_n)
    else $error("write strobe seen without select");
  rd_select_a: assert property (!rd_n |-> !cs_n)
    else $error("read strobe seen without select");
  wr_hold_a: assert property (wr_start_s |=> (!wr_n && host_data_oe && $stable(host_data))[*7])
    else $error("write data or strobe not held");
  cs_lead_a: assert property ($fell(cs_n) |=> any_strobe_s)
    else $error("strobe did not follow select");
  cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("select gap too short");
  // Sync lag: drive may only follow a selected read by two to four cycles
  oe_cause_a: assert property (dev_data_oe |-> $past(sel_rd, 2) || $past(sel_rd, 3) || $past(sel_rd, 4))
    else $error("data driven outside a selected read");
  oe_on_a: assert property (rd_held_s |-> dev_data_oe)
    else $error("data not driven during a read");
  oe_off_a: assert property ($rose(rd_n) |-> ##[1:4] !dev_data_oe)
    else $error("data drive not released after read");
  no_fight_a: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive the data lines");
endmodule : psp_monitor

// file: test_parallel_slave_port.sv
// Self-checking bench driving both ends of the slave port
`timescale 1ns/1ns
module test_parallel_slave_port
  import psp_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        we = 1'b0, re = 1'b0;
  psp_byte_t   fa = 8'h00, fd = 8'h00, dir = 8'h0F;
  psp_byte_t   frd, doe;
  logic        d_irq, h_irq, awr, wrdy, bv, arr, rv;
  logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [31:0] aa = 32'h0, wd = 32'h0, ra = 32'h0;
  logic [31:0] rdat, ad;
  logic [1:0]  bresp, rresp, ar;
  int          miscompares = 0;
  int          samples_checked = 0;
  always #50 clk = ~clk;
  psp_bus_if psp_bus_if_inst ();
  psp_device psp_device_inst (
    .CLK(clk), .RST(rst), .REG_WE(we), .REG_RE(re), .REG_ADDR(fa), .REG_WDATA(fd),
    .REG_RDATA(frd), .DATA_PIN_DIRECTION(dir), .DATA_OUT_OE(doe), .IRQ(d_irq),
    .bus(psp_bus_if_inst.device));
  psp_host psp_host_inst (
    .CLK(clk), .RST(rst), .S_AXI_AWADDR(aa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ra),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .IRQ(h_irq), .bus(psp_bus_if_inst.host));
  psp_monitor psp_monitor_inst (
    .CLK(clk), .RST(rst), .cs_n(psp_bus_if_inst.cs_n), .rd_n(psp_bus_if_inst.rd_n),
    .wr_n(psp_bus_if_inst.wr_n), .host_data(psp_bus_if_inst.host_data),
    .host_data_oe(psp_bus_if_inst.host_data_oe), .dev_data_oe(psp_bus_if_inst.dev_data_oe));
  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic give_verdict;
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic tmo(input int n);
    if (n > 60) begin
      miscompares++;
      give_verdict();
    end
  endtask : tmo
  task automatic fw_wr(input psp_byte_t a, d);
    @(posedge clk);
    we <= 1'b1;
    fa <= a;
    fd <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask : fw_wr
  task automatic fw_chk(input psp_byte_t a, e);
    @(posedge clk);
    re <= 1'b1;
    fa <= a;
    @(posedge clk);
    re <= 1'b0;
    @(posedge clk);
    chk($sformatf("reg_%h", a), frd, e);
  endtask : fw_chk
  // Address and data offered together, each dropped at its own handshake
  task automatic ax_wr(input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge clk);
    aa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wrdy === 1'b1) wv <= 1'b0;
      n++;
      tmo(n);
    end while (bv !== 1'b1);
    chk("axi_bresp", bresp, (a > 32'h10) ? 2'h2 : 2'h0);
    br <= 1'b0;
  endtask : ax_wr
  task automatic ax_rd(input logic [31:0] a);
    int n;
    n = 0;
    @(posedge clk);
    ra <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr === 1'b1) arv <= 1'b0;
      n++;
      tmo(n);
    end while (rv !== 1'b1);
    ad = rdat;
    ar = rresp;
    rr <= 1'b0;
  endtask : ax_rd
  task automatic ax_chk(input logic [31:0] a, e, input logic [1:0] r);
    ax_rd(a);
    chk("axi_data", ad, e);
    chk("axi_resp", ar, r);
  endtask : ax_chk
  task automatic wait_ev(input int b);
    int n;
    n = 0;
    ad = 32'h0;
    while (ad[b] !== 1'b1) begin
      ax_rd(32'hC);
      n++;
      tmo(n);
    end
  endtask : wait_ev
  // Command value c (bit c-1) raises done bit c in the host status
  task automatic host_op(input int c, input psp_byte_t b);
    ax_wr(32'h4, {24'h0, b});
    ax_wr(32'h0, c);
    wait_ev(c);
    ax_wr(32'hC, 32'h6);
  endtask : host_op
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_idle;
    fw_chk(8'h89, 8'h07);
    fw_chk(8'h0C, 8'h00);
    fw_chk(8'h8C, 8'h00);
    fw_chk(8'h9F, 8'h00);
    fw_chk(8'h50, 8'h00);
    ax_chk(32'h14, 32'h0, 2'h2);
    ax_wr(32'h14, 32'h0);
    chk("data_oe", doe, 8'hF0);
    host_op(1, 8'h11);
    fw_chk(8'h89, 8'h07);
    fw_chk(8'h0C, 8'h00);
  endtask : t_idle
  task automatic t_write;
    fw_wr(8'h9F, 8'h07);
    fw_wr(8'h89, 8'h17);
    fw_chk(8'h89, 8'h17);
    chk("data_oe", doe, 8'h00);
    host_op(1, 8'hA5);
    fw_chk(8'h89, 8'h97);
    fw_chk(8'h0C, 8'h80);
    fw_chk(8'h89, 8'h97);
    fw_chk(8'h08, 8'hA5);
    fw_chk(8'h89, 8'h17);
    fw_wr(8'h0C, 8'h00);
  endtask : t_write
  task automatic t_overflow;
    host_op(1, 8'h5A);
    host_op(1, 8'hC3);
    fw_chk(8'h89, 8'hB7);
    fw_chk(8'h08, 8'hC3);
    fw_wr(8'h89, 8'h27);
    fw_chk(8'h89, 8'h27);
    fw_wr(8'h89, 8'h17);
    fw_chk(8'h89, 8'h17);
    fw_wr(8'h0C, 8'h00);
  endtask : t_overflow
  task automatic t_read;
    fw_wr(8'h08, 8'h3C);
    fw_chk(8'h89, 8'h57);
    fw_wr(8'h8C, 8'h80);
    host_op(2, 8'h00);
    ax_chk(32'h8, 32'h3C, 2'h0);
    fw_chk(8'h89, 8'h17);
    fw_chk(8'h0C, 8'h80);
    chk("dev_irq", d_irq, 1'b1);
    fw_wr(8'h0C, 8'h00);
    fw_chk(8'h0C, 8'h00);
    chk("dev_irq", d_irq, 1'b0);
    fw_wr(8'h8C, 8'h00);
    host_op(2, 8'h00);
    fw_chk(8'h0C, 8'h80);
    chk("dev_irq", d_irq, 1'b0);
  endtask : t_read
  task automatic t_host_irq;
    ax_wr(32'h4, 32'h66);
    ax_wr(32'h0, 32'h1);
    wait_ev(1);
    chk("host_irq", h_irq, 1'b0);
    ax_wr(32'h10, 32'h3);
    ax_rd(32'h10);
    chk("host_irq", h_irq, 1'b1);
    ax_wr(32'hC, 32'h6);
    ax_chk(32'hC, 32'h0, 2'h0);
    chk("host_irq", h_irq, 1'b0);
  endtask : t_host_irq
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_idle();
    t_write();
    t_overflow();
    t_read();
    t_host_irq();
    give_verdict();
  end
endmodule : test_parallel_slave_port
